// ### logic/pod_cfg.svh
`ifndef POD_CFG_SVH
`define POD_CFG_SVH

// Field slices of the operation word
`define POD_F_CAT 15:12
`define POD_F_SUB 11:9
`define POD_F_HI 11:8
`define POD_F_MODE 8:6
`define POD_F_SZ 7:6
`define POD_F_EAM 5:3
`define POD_F_EAR 2:0
`define POD_F_DISP 7:0
`define POD_F_QDATA 7:0
`define POD_B_OPM 8
`define POD_B_TYPE 8
`define POD_B_MSZ 6
`define POD_B_MDIR 10
`define POD_B_RM 3
`define POD_B_CDIR 0
// Field slices of the extension word
`define POD_X_CREG 11:0
`define POD_X_DIR 11
`define POD_X_TYPE 11
`define POD_X_SIZE 10

// Categories
`define POD_CAT_BITIMM 4'h0
`define POD_CAT_MISC 4'h4
`define POD_CAT_QUICK 4'h5
`define POD_CAT_BRANCH 4'h6
`define POD_CAT_QMOVE 4'h7
`define POD_CAT_ORDIV 4'h8
`define POD_CAT_SUB 4'h9
`define POD_CAT_RSVD 4'ha
`define POD_CAT_CMP 4'hb

// Opcode patterns
`define POD_OP_ALTMV 4'he
`define POD_OP_SBIT 4'h8
`define POD_OP_CCRSR 6'h3c
`define POD_OP_MULL 6'h30
`define POD_OP_DIVL 6'h31
`define POD_OP_CREG 11'h73d
`define POD_OP_LINKL 9'h101
`define POD_OP_LINKW 9'h1ca
`define POD_OP_RTD 12'he74
`define POD_OP_STOP 12'he72
`define POD_OP_ILL 12'hafc
`define POD_OP_TRAP_ON_CONDITION 5'h1f
`define POD_OP_DBCC 5'h19
`define POD_OP_DECIMAL_SUBTRACT_EXT 5'h10
`define POD_OP_ALW 4'h0
`define POD_OP_SUBR 4'h1
`define POD_OP_SEXT 3'h4
`define POD_OP_MMOVE 3'h1

// Field values
`define POD_SZ_B 2'h0
`define POD_SZ_W 2'h1
`define POD_SZ_L 2'h2
`define POD_SZ_X 2'h3
`define POD_CHK_L 2'h2
`define POD_CHK_W 2'h3
`define POD_SX_BW 3'h2
`define POD_SX_WL 3'h3
`define POD_SX_BL 3'h7
`define POD_SA_W 3'h3
`define POD_SA_L 3'h7
`define POD_TO_W 3'h2
`define POD_TO_L 3'h3
`define POD_TO_N 3'h4
`define POD_D16 8'h00
`define POD_D32 8'hff
`define POD_EAM_DREG 3'h0
`define POD_EAM_AREG 3'h1
`define POD_QZERO_VAL 4'h8
`define POD_XW_0 2'h0
`define POD_XW_1 2'h1
`define POD_XW_2 2'h2

// Condition codes
`define POD_CC_T 4'h0
`define POD_CC_F 4'h1
`define POD_CC_HI 4'h2
`define POD_CC_LS 4'h3
`define POD_CC_CC 4'h4
`define POD_CC_CS 4'h5
`define POD_CC_NE 4'h6
`define POD_CC_EQ 4'h7
`define POD_CC_VC 4'h8
`define POD_CC_VS 4'h9
`define POD_CC_PL 4'ha
`define POD_CC_MI 4'hb
`define POD_CC_GE 4'hc
`define POD_CC_LT 4'hd
`define POD_CC_GT 4'he
`define POD_CC_LE 4'hf

// Control register selectors
`define POD_CR_SFC 12'h000
`define POD_CR_DFC 12'h001
`define POD_CR_CACHE 12'h002
`define POD_CR_USP 12'h800
`define POD_CR_VBR 12'h801
`define POD_CR_CADDR 12'h802
`define POD_CR_MSP 12'h803
`define POD_CR_ISP 12'h804

`endif

// ### logic/pod_pkg.sv
`default_nettype none
package pod_pkg;

  typedef enum logic [1:0] {
    POD_BYTE = 2'h0,
    POD_WORD = 2'h1,
    POD_LONG = 2'h2,
    POD_NOSZ = 2'h3
  } pod_size_t;

  typedef enum logic [4:0] {
    POD_C_NONE = 5'h00,
    POD_C_IMM = 5'h01,
    POD_C_BIT = 5'h02,
    POD_C_ALTMV = 5'h03,
    POD_C_MISC = 5'h04,
    POD_C_BOUND = 5'h05,
    POD_C_SEXT = 5'h06,
    POD_C_MMOVE = 5'h07,
    POD_C_MULL = 5'h08,
    POD_C_DIVL = 5'h09,
    POD_C_CREG = 5'h0a,
    POD_C_QADD = 5'h0b,
    POD_C_QSUB = 5'h0c,
    POD_C_CONDOP = 5'h0d,
    POD_C_TRAP_ON_CONDITION = 5'h0e,
    POD_C_BRANCH = 5'h0f,
    POD_C_QMOVE = 5'h10,
    POD_C_OR = 5'h11,
    POD_C_DIVW = 5'h12,
    POD_C_DSUBX = 5'h13,
    POD_C_SUB = 5'h14,
    POD_C_SUBTRACT_TO_AREG = 5'h15,
    POD_C_SUBX = 5'h16,
    POD_C_CMP = 5'h17
  } pod_class_t;

  typedef enum logic [3:0] {
    POD_CR_NONE = 4'h0,
    POD_CR_SRC_FC = 4'h1,
    POD_CR_DST_FC = 4'h2,
    POD_CR_CACHE_CTL = 4'h3,
    POD_CR_USER_SP = 4'h4,
    POD_CR_VEC_BASE = 4'h5,
    POD_CR_CACHE_ADR = 4'h6,
    POD_CR_MASTER_SP = 4'h7,
    POD_CR_INTR_SP = 4'h8
  } pod_creg_t;

endpackage : pod_pkg
`default_nettype wire

// ### logic/pod_cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
`include "pod_cfg.svh"
module pod_cond_eval
  import pod_pkg::*;
(
  // Condition select
  input wire logic [3:0] cond,
  // Flags n z v c
  input wire logic [3:0] flags,
  // Result
  output logic holds
);
  logic n;
  logic z;
  logic v;
  logic c;
  assign {n, z, v, c} = flags;

  // Flag test per code
  always_comb begin
    case (cond)
      `POD_CC_T: holds = 1'b1;
      `POD_CC_F: holds = 1'b0;
      `POD_CC_HI: holds = !c && !z;
      `POD_CC_LS: holds = c || z;
      `POD_CC_CC: holds = !c;
      `POD_CC_CS: holds = c;
      `POD_CC_NE: holds = !z;
      `POD_CC_EQ: holds = z;
      `POD_CC_VC: holds = !v;
      `POD_CC_VS: holds = v;
      `POD_CC_PL: holds = !n;
      `POD_CC_MI: holds = n;
      `POD_CC_GE: holds = n == v;
      `POD_CC_LT: holds = n != v;
      `POD_CC_GT: holds = (n == v) && !z;
      `POD_CC_LE: holds = z || (n != v);
      default: holds = 1'b0;
    endcase
  end
endmodule : pod_cond_eval
`default_nettype wire

// ### logic/pod_creg_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "pod_cfg.svh"
module pod_creg_sel
  import pod_pkg::*;
(
  // Selector field
  input wire logic [11:0] sel,
  // Decoded register
  output pod_creg_t creg,
  output logic known
);
  // Selector to register
  always_comb begin
    case (sel)
      `POD_CR_SFC: creg = POD_CR_SRC_FC;
      `POD_CR_DFC: creg = POD_CR_DST_FC;
      `POD_CR_CACHE: creg = POD_CR_CACHE_CTL;
      `POD_CR_USP: creg = POD_CR_USER_SP;
      `POD_CR_VBR: creg = POD_CR_VEC_BASE;
      `POD_CR_CADDR: creg = POD_CR_CACHE_ADR;
      `POD_CR_MSP: creg = POD_CR_MASTER_SP;
      `POD_CR_ISP: creg = POD_CR_INTR_SP;
      default: creg = POD_CR_NONE;
    endcase
  end
  assign known = creg != POD_CR_NONE;
endmodule : pod_creg_sel
`default_nettype wire

// ### logic/pod_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "pod_cfg.svh"

// What this block does
// - Top four bits pick the category first
// - Condition codes map to their flag tests
// - Size 00 byte, 01 word, 10 long
// - Alt-space move: 0 ea-to-reg, 1 reg-to-ea
// - Bound check size 10 long, 11 word
// - Sign extend modes 010, 011, 111
// - Multi move size bit, mask from extension
// - Long multiply type and product width bits
// - Long divide dividend width and type bits
// - Word divide type bit: unsigned or signed
// - Control move: 0 to general, 1 to control
// - Control selector decodes eight named registers
// - Quick data 1-7 literal, 0 means 8
// - Branch disp 00 adds word, ff long
// - Quick move sign-extends data to 32 bits
// - Subtract modes choose destination and operand order
// - Subtract-to-address 011 word, 111 long
// - Decimal subtract register or predecrement memory form
// - Conditional trap operand words 1, 2, 0
module pod_decoder
  import pod_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Fetched words
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  input wire logic [15:0] ext_word,
  input wire logic [3:0] ccr_flags,
  // Decoded fields
  output logic dec_valid_q,
  output logic [3:0] category_q,
  output pod_class_t op_class_q,
  output pod_size_t op_size_q,
  output logic to_ea_q,
  output logic is_signed_q,
  output logic wide_q,
  output logic mem_to_mem_q,
  output logic [3:0] quick_imm_q,
  output logic [31:0] quick_data_q,
  output logic [15:0] reg_mask_q,
  output pod_creg_t ctrl_reg_q,
  output logic cond_true_q,
  output logic [1:0] ext_words_q,
  output logic illegal_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Field matching

  logic [3:0] cat;
  logic [1:0] sz;
  logic [2:0] opm;
  logic [2:0] eam;
  logic [7:0] disp8;
  pod_size_t size_std;
  assign cat = op_word[`POD_F_CAT];
  assign sz = op_word[`POD_F_SZ];
  assign opm = op_word[`POD_F_MODE];
  assign eam = op_word[`POD_F_EAM];
  assign disp8 = op_word[`POD_F_DISP];
  assign size_std = (sz == `POD_SZ_B) ? POD_BYTE :
                    (sz == `POD_SZ_W) ? POD_WORD :
                    (sz == `POD_SZ_L) ? POD_LONG : POD_NOSZ;

  logic c_bit;
  logic c_misc;
  logic c_quick;
  logic c_ordiv;
  logic c_sub;
  assign c_bit = cat == `POD_CAT_BITIMM;
  assign c_misc = cat == `POD_CAT_MISC;
  assign c_quick = cat == `POD_CAT_QUICK;
  assign c_ordiv = cat == `POD_CAT_ORDIV;
  assign c_sub = cat == `POD_CAT_SUB;

  logic m_altmv;
  logic m_chk2;
  logic m_sbit;
  logic m_ccrsr;
  assign m_altmv = c_bit && op_word[`POD_F_HI] == `POD_OP_ALTMV;
  assign m_chk2 = c_bit && !op_word[11] && !op_word[8] && sz == `POD_SZ_X;
  assign m_sbit = c_bit && op_word[`POD_F_HI] == `POD_OP_SBIT;
  assign m_ccrsr = op_word[5:0] == `POD_OP_CCRSR && !op_word[7];

  logic sext_ok;
  assign sext_ok = opm == `POD_SX_BW || opm == `POD_SX_WL || opm == `POD_SX_BL;

  logic m_bound;
  logic m_sext;
  logic m_mmove;
  logic m_mull;
  logic m_divl;
  logic m_creg;
  logic m_ext1;
  logic m_linkl;
  logic m_illop;
  assign m_bound = c_misc && op_word[8] && !op_word[6];
  assign m_sext = c_misc && op_word[`POD_F_SUB] == `POD_OP_SEXT && eam == `POD_EAM_DREG &&
                  sext_ok;
  assign m_mmove = c_misc && op_word[11] && op_word[9:7] == `POD_OP_MMOVE;
  assign m_mull = c_misc && op_word[11:6] == `POD_OP_MULL;
  assign m_divl = c_misc && op_word[11:6] == `POD_OP_DIVL;
  assign m_creg = c_misc && op_word[11:1] == `POD_OP_CREG;
  assign m_linkl = op_word[11:3] == `POD_OP_LINKL;
  assign m_ext1 = op_word[11:3] == `POD_OP_LINKW || op_word[11:0] == `POD_OP_RTD ||
                  op_word[11:0] == `POD_OP_STOP;
  assign m_illop = op_word[11:0] == `POD_OP_ILL;

  logic bnd_sz;
  assign bnd_sz = op_word[8:7] == `POD_CHK_W;

  pod_creg_t creg_dec;
  logic creg_known;
  logic cond_hold;

  pod_creg_sel u_creg (
    .sel(ext_word[`POD_X_CREG]),
    .creg(creg_dec),
    .known(creg_known)
  );

  pod_cond_eval u_cond (
    .cond(op_word[`POD_F_HI]),
    .flags(ccr_flags),
    .holds(cond_hold)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Class, size, extension count and error

  pod_class_t cls_d;
  pod_size_t size_d;
  logic [1:0] ext_d;
  logic to_ea_d;
  logic sgn_d;
  logic wide_d;
  logic bad_d;

  always_comb begin
    cls_d = POD_C_NONE;
    size_d = POD_NOSZ;
    ext_d = `POD_XW_0;
    to_ea_d = 1'b0;
    sgn_d = 1'b0;
    wide_d = 1'b0;
    bad_d = 1'b0;
    case (cat)
      `POD_CAT_BITIMM: begin
        if (op_word[8]) begin
          cls_d = POD_C_BIT;
          ext_d = (eam == `POD_EAM_AREG) ? `POD_XW_1 : `POD_XW_0;
        end else if (m_sbit) begin
          cls_d = POD_C_BIT;
          ext_d = `POD_XW_1;
        end else if (m_altmv) begin
          cls_d = POD_C_ALTMV;
          size_d = size_std;
          ext_d = `POD_XW_1;
          to_ea_d = ext_word[`POD_X_DIR];
          bad_d = size_std == POD_NOSZ;
        end else if (m_chk2) begin
          cls_d = POD_C_IMM;
          size_d = (op_word[10:9] == `POD_SZ_B) ? POD_BYTE :
                   (op_word[10:9] == `POD_SZ_W) ? POD_WORD :
                   (op_word[10:9] == `POD_SZ_L) ? POD_LONG : POD_NOSZ;
          ext_d = `POD_XW_1;
          bad_d = op_word[10:9] == `POD_SZ_X;
        end else begin
          cls_d = POD_C_IMM;
          size_d = size_std;
          ext_d = (m_ccrsr || size_std != POD_LONG) ? `POD_XW_1 : `POD_XW_2;
        end
      end
      `POD_CAT_MISC: begin
        cls_d = POD_C_MISC;
        if (m_sext) begin
          cls_d = POD_C_SEXT;
          size_d = (opm == `POD_SX_BW) ? POD_WORD : POD_LONG;
        end else if (m_bound) begin
          cls_d = POD_C_BOUND;
          size_d = bnd_sz ? POD_WORD : POD_LONG;
        end else if (m_mmove) begin
          cls_d = POD_C_MMOVE;
          size_d = op_word[`POD_B_MSZ] ? POD_LONG : POD_WORD;
          to_ea_d = !op_word[`POD_B_MDIR];
          ext_d = `POD_XW_1;
        end else if (m_mull || m_divl) begin
          cls_d = m_mull ? POD_C_MULL : POD_C_DIVL;
          size_d = POD_LONG;
          sgn_d = ext_word[`POD_X_TYPE];
          wide_d = ext_word[`POD_X_SIZE];
          ext_d = `POD_XW_1;
        end else if (m_creg) begin
          cls_d = POD_C_CREG;
          size_d = POD_LONG;
          to_ea_d = op_word[`POD_B_CDIR];
          ext_d = `POD_XW_1;
          bad_d = !creg_known;
        end else begin
          ext_d = m_linkl ? `POD_XW_2 : m_ext1 ? `POD_XW_1 : `POD_XW_0;
          bad_d = m_illop;
        end
      end
      `POD_CAT_QUICK: begin
        if (sz != `POD_SZ_X) begin
          cls_d = op_word[`POD_B_OPM] ? POD_C_QSUB : POD_C_QADD;
          size_d = size_std;
        end else if (op_word[7:3] == `POD_OP_TRAP_ON_CONDITION) begin
          cls_d = POD_C_TRAP_ON_CONDITION;
          ext_d = (op_word[`POD_F_EAR] == `POD_TO_W) ? `POD_XW_1 :
                  (op_word[`POD_F_EAR] == `POD_TO_L) ? `POD_XW_2 : `POD_XW_0;
          bad_d = op_word[`POD_F_EAR] != `POD_TO_W && op_word[`POD_F_EAR] != `POD_TO_L &&
                  op_word[`POD_F_EAR] != `POD_TO_N;
        end else begin
          cls_d = POD_C_CONDOP;
          ext_d = (op_word[7:3] == `POD_OP_DBCC) ? `POD_XW_1 : `POD_XW_0;
        end
      end
      `POD_CAT_BRANCH: begin
        cls_d = POD_C_BRANCH;
        ext_d = (disp8 == `POD_D16) ? `POD_XW_1 :
                (disp8 == `POD_D32) ? `POD_XW_2 : `POD_XW_0;
      end
      `POD_CAT_QMOVE: begin
        cls_d = POD_C_QMOVE;
        size_d = POD_LONG;
        bad_d = op_word[8];
      end
      `POD_CAT_ORDIV: begin
        if (sz == `POD_SZ_X) begin
          cls_d = POD_C_DIVW;
          size_d = POD_WORD;
          sgn_d = op_word[`POD_B_TYPE];
        end else if (op_word[8:4] == `POD_OP_DECIMAL_SUBTRACT_EXT) begin
          cls_d = POD_C_DSUBX;
          size_d = POD_BYTE;
        end else begin
          cls_d = POD_C_OR;
          size_d = size_std;
          to_ea_d = op_word[`POD_B_OPM];
        end
      end
      `POD_CAT_SUB: begin
        if (sz == `POD_SZ_X) begin
          cls_d = POD_C_SUBTRACT_TO_AREG;
          size_d = (opm == `POD_SA_W) ? POD_WORD : POD_LONG;
        end else if (op_word[8] && op_word[5:4] == `POD_SZ_B) begin
          cls_d = POD_C_SUBX;
          size_d = size_std;
        end else begin
          cls_d = POD_C_SUB;
          size_d = size_std;
          to_ea_d = op_word[`POD_B_OPM];
        end
      end
      `POD_CAT_CMP: begin
        cls_d = POD_C_CMP;
        size_d = (sz != `POD_SZ_X) ? size_std : op_word[8] ? POD_LONG : POD_WORD;
      end
      `POD_CAT_RSVD: bad_d = 1'b1;
      default: cls_d = POD_C_NONE;
    endcase
  end

  logic [3:0] qimm_d;
  logic [31:0] qdata_d;
  logic m2m_d;
  assign qimm_d = (op_word[`POD_F_SUB] == 3'h0) ? `POD_QZERO_VAL :
                  {1'b0, op_word[`POD_F_SUB]};
  assign qdata_d = {{24{op_word[7]}}, op_word[`POD_F_QDATA]};
  assign m2m_d = op_word[`POD_B_RM];

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      dec_valid_q <= op_valid;
      illegal_q <= op_valid && bad_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      category_q <= 4'h0;
      op_class_q <= POD_C_NONE;
      op_size_q <= POD_NOSZ;
      ext_words_q <= `POD_XW_0;
      to_ea_q <= 1'b0;
      is_signed_q <= 1'b0;
      wide_q <= 1'b0;
      mem_to_mem_q <= 1'b0;
    end else if (op_valid) begin
      category_q <= cat;
      op_class_q <= cls_d;
      op_size_q <= size_d;
      ext_words_q <= ext_d;
      to_ea_q <= to_ea_d;
      is_signed_q <= sgn_d;
      wide_q <= wide_d;
      mem_to_mem_q <= m2m_d && (cls_d == POD_C_DSUBX || cls_d == POD_C_SUBX);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      quick_imm_q <= 4'h0;
      quick_data_q <= 32'h0;
      reg_mask_q <= 16'h0;
      ctrl_reg_q <= POD_CR_NONE;
      cond_true_q <= 1'b0;
    end else if (op_valid) begin
      quick_imm_q <= qimm_d;
      quick_data_q <= qdata_d;
      reg_mask_q <= m_mmove ? ext_word : 16'h0;
      ctrl_reg_q <= m_creg ? creg_dec : POD_CR_NONE;
      cond_true_q <= cond_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_taken;
    op_valid;
  endsequence

  property p_cat;
    s_taken |=> category_q == $past(op_word[15:12]) && dec_valid_q;
  endproperty
  a_cat: assert property (p_cat) else $error("category mismatch");

  property p_rsvd;
    s_taken ##0 (op_word[15:12] == 4'ha) |=> illegal_q;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved not flagged");

  property p_qimm;
    dec_valid_q && (op_class_q == POD_C_QADD || op_class_q == POD_C_QSUB) |->
      quick_imm_q == (($past(op_word[11:9]) == 3'h0) ? 4'h8 : {1'b0, $past(op_word[11:9])});
  endproperty
  a_qimm: assert property (p_qimm) else $error("quick value wrong");

  property p_qmove;
    dec_valid_q && op_class_q == POD_C_QMOVE |->
      quick_data_q == {{24{$past(op_word[7])}}, $past(op_word[7:0])} &&
      op_size_q == POD_LONG;
  endproperty
  a_qmove: assert property (p_qmove) else $error("quick move not extended");

  property p_branch;
    s_taken ##0 (op_word[15:12] == 4'h6) |=>
      ext_words_q == (($past(op_word[7:0]) == 8'h00) ? 2'h1 :
                      ($past(op_word[7:0]) == 8'hff) ? 2'h2 : 2'h0);
  endproperty
  a_branch: assert property (p_branch) else $error("branch count wrong");

  property p_trap_on_condition;
    dec_valid_q && op_class_q == POD_C_TRAP_ON_CONDITION && !illegal_q |->
      ext_words_q == (($past(op_word[2:0]) == 3'h2) ? 2'h1 :
                      ($past(op_word[2:0]) == 3'h3) ? 2'h2 : 2'h0);
  endproperty
  a_trap_on_condition: assert property (p_trap_on_condition) else $error("trap operand count wrong");

  property p_bound;
    dec_valid_q && op_class_q == POD_C_BOUND |->
      op_size_q == (($past(op_word[8:7]) == 2'h3) ? POD_WORD : POD_LONG);
  endproperty
  a_bound: assert property (p_bound) else $error("bound size wrong");

  property p_divw;
    dec_valid_q && op_class_q == POD_C_DIVW |-> is_signed_q == $past(op_word[8]);
  endproperty
  a_divw: assert property (p_divw) else $error("divide type wrong");

  property p_creg;
    dec_valid_q && op_class_q == POD_C_CREG |->
      (ctrl_reg_q == POD_CR_NONE) == illegal_q && to_ea_q == $past(op_word[0]);
  endproperty
  a_creg: assert property (p_creg) else $error("control move wrong");

  property p_hold;
    !op_valid |=> $stable(op_class_q) && $stable(ext_words_q) && !illegal_q;
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved while idle");

endmodule : pod_decoder
`default_nettype wire

// ### verif/test_primary_opword_field_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_primary_opword_field_decoder
  import pod_pkg::*;
;
  ////////////////////////////////////////////////////////////
  // Stimulus and observed outputs
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic [15:0] op_word = 16'h0000;
  logic [15:0] ext_word = 16'h0000;
  logic [3:0] ccr_flags = 4'h0;
  logic dec_valid_q, to_ea_q, is_signed_q, wide_q, mem_to_mem_q, cond_true_q, illegal_q;
  logic [3:0] category_q, quick_imm_q;
  logic [31:0] quick_data_q;
  logic [15:0] reg_mask_q;
  logic [1:0] ext_words_q;
  pod_class_t op_class_q;
  pod_size_t op_size_q;
  pod_creg_t ctrl_reg_q;
  int errors = 0;
  int compares = 0;
  integer seed = 32'h8d2c;
  logic [15:0] op, ext;
  logic [11:0] sel [9] = '{12'h000, 12'h001, 12'h002, 12'h800, 12'h801,
                           12'h802, 12'h803, 12'h804, 12'h805};
  logic [15:0] xop [10] = '{16'h0680, 16'h0640, 16'h0838, 16'h0108, 16'h4808,
                            16'h4e50, 16'h4e75, 16'h51c8, 16'hb041, 16'h8041};
  pod_class_t xcls [10] = '{POD_C_IMM, POD_C_IMM, POD_C_BIT, POD_C_BIT, POD_C_MISC,
                            POD_C_MISC, POD_C_MISC, POD_C_CONDOP, POD_C_CMP, POD_C_OR};
  int xcnt [10] = '{2, 1, 1, 1, 2, 1, 0, 1, 0, 0};

  always #12.5 ref_clk = ~ref_clk;

  pod_decoder u_dut (
    .ref_clk, .rst_n, .op_valid, .op_word, .ext_word, .ccr_flags, .dec_valid_q,
    .category_q, .op_class_q, .op_size_q, .to_ea_q, .is_signed_q, .wide_q,
    .mem_to_mem_q, .quick_imm_q, .quick_data_q, .reg_mask_q, .ctrl_reg_q,
    .cond_true_q, .ext_words_q, .illegal_q
  );

  ////////////////////////////////////////////////////////////
  // Model and checking tasks
  function automatic logic [15:0] rnd();
    return 16'($random(seed));
  endfunction : rnd

  // Odd codes are the complement of the even code below them
  function automatic logic cc_model(input logic [3:0] cc, input logic [3:0] f);
    logic n, z, v, c, b;
    {n, z, v, c} = f;
    case (cc[3:1])
      3'h0: b = 1'b1;
      3'h1: b = !c && !z;
      3'h2: b = !c;
      3'h3: b = !z;
      3'h4: b = !v;
      3'h5: b = !n;
      3'h6: b = n == v;
      default: b = (n == v) && !z;
    endcase
    return b ^ cc[0];
  endfunction : cc_model

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic dec(input logic [15:0] o, input logic [15:0] x, input logic ill);
    logic [3:0] f;
    f = 4'(rnd());
    op_valid = 1'b1;
    op_word = o;
    ext_word = x;
    ccr_flags = f;
    @(posedge ref_clk);
    #1;
    chk("valid", dec_valid_q, 1);
    chk("category", category_q, o[15:12]);
    chk("cond", cond_true_q, cc_model(o[11:8], f));
    chk("illegal", illegal_q, ill);
  endtask : dec

  task automatic idle(input string nm);
    logic [3:0] c;
    c = category_q;
    op_valid = 1'b0;
    op_word = rnd();
    @(posedge ref_clk);
    #1;
    chk("idle valid", dec_valid_q, 0);
    chk("held", category_q, c);
    $display("test %s done", nm);
  endtask : idle

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #1ms;
    errors++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    chk("rst valid", dec_valid_q, 0);
    chk("rst size", op_size_q, POD_NOSZ);
    chk("rst class", op_class_q, POD_C_NONE);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      op = {4'h7, 3'(rnd()), 1'b0, 8'(rnd())};
      dec(op, rnd(), 0);
      chk("qdata", quick_data_q, {{24{op[7]}}, op[7:0]});
      chk("qsize", op_size_q, POD_LONG);
      chk("qclass", op_class_q, POD_C_QMOVE);
    end
    idle("quick move");
    for (int i = 0; i < 16; i++) begin
      dec({4'h5, 3'(i), i[3], 2'(i % 3), 6'h10}, rnd(), 0);
      chk("qimm", quick_imm_q, (i % 8 == 0) ? 8 : i % 8);
      chk("qsize", op_size_q, i % 3);
      chk("qcls", op_class_q, i[3] ? POD_C_QSUB : POD_C_QADD);
    end
    idle("quick add sub");
    for (int i = 0; i < 3; i++) begin
      dec({4'h6, 4'(rnd()), (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'h42}, rnd(), 0);
      chk("bext", ext_words_q, (i == 0) ? 1 : (i == 1) ? 2 : 0);
    end
    idle("branch");
    for (int i = 0; i < 9; i++) begin
      dec(16'h4e7a | 16'(i[0]), {4'(rnd()), sel[i]}, i == 8);
      chk("cclass", op_class_q, POD_C_CREG);
      chk("cdir", to_ea_q, i[0]);
      chk("creg", ctrl_reg_q, (i < 8) ? i + 1 : 0);
    end
    idle("control move");
    for (int i = 0; i < 3; i++) begin
      dec({7'b0100100, (i == 0) ? 3'h2 : (i == 1) ? 3'h3 : 3'h7, 3'h0, 3'(rnd())}, rnd(), 0);
      chk("sxsize", op_size_q, (i == 0) ? POD_WORD : POD_LONG);
      chk("sxcls", op_class_q, POD_C_SEXT);
    end
    idle("sign extend");
    for (int i = 0; i < 8; i++) begin
      ext = {1'b0, 3'(rnd()), i[0], i[1], 7'h00, 3'(rnd())};
      dec(i[2] ? 16'h4c40 : 16'h4c00, ext, 0);
      chk("lclass", op_class_q, i[2] ? POD_C_DIVL : POD_C_MULL);
      chk("lsign", is_signed_q, i[0]);
      chk("lwide", wide_q, i[1]);
      dec({4'h8, 3'(rnd()), i[0], 8'hc2}, rnd(), 0);
      chk("wsign", is_signed_q, i[0]);
      dec({4'h8, 3'(rnd()), 5'h10, i[0], 3'(rnd())}, rnd(), 0);
      chk("bcd", mem_to_mem_q, i[0]);
      chk("bcdcls", op_class_q, POD_C_DSUBX);
      dec({4'h9, 3'(rnd()), 1'b1, 2'(i % 3), 2'b00, i[0], 3'(rnd())}, rnd(), 0);
      chk("subxcls", op_class_q, POD_C_SUBX);
      chk("subxm2m", mem_to_mem_q, i[0]);
    end
    idle("multiply divide");
    for (int m = 0; m < 8; m++) begin
      dec({4'h9, 3'(rnd()), 3'(m), 6'h13}, rnd(), 0);
      if (m % 4 == 3) begin
        chk("sacls", op_class_q, POD_C_SUBTRACT_TO_AREG);
        chk("sasize", op_size_q, (m == 3) ? POD_WORD : POD_LONG);
      end else begin
        chk("scls", op_class_q, POD_C_SUB);
        chk("ssize", op_size_q, m % 4);
        chk("sdir", to_ea_q, m / 4);
      end
    end
    idle("subtract");
    for (int m = 2; m < 6; m++) begin
      dec({4'h5, 4'(rnd()), 5'h1f, 3'(m)}, rnd(), m == 5);
      chk("text", ext_words_q, (m == 2) ? 1 : (m == 3) ? 2 : 0);
    end
    idle("trap");
    for (int k = 0; k < 10; k++) begin
      dec(xop[k], rnd(), 0);
      chk("xcls", op_class_q, xcls[k]);
      chk("xext", ext_words_q, xcnt[k]);
    end
    idle("extension count");
    for (int i = 0; i < 6; i++) begin
      dec({8'h0e, 2'(i % 3), 6'h10}, {1'b0, 3'(rnd()), i[0], 11'h000}, 0);
      chk("acls", op_class_q, POD_C_ALTMV);
      chk("adir", to_ea_q, i[0]);
      chk("asize", op_size_q, i % 3);
      dec({4'h4, 3'(rnd()), 1'b1, i[0], 7'h02}, rnd(), 0);
      chk("bsize", op_size_q, i[0] ? POD_WORD : POD_LONG);
      ext = rnd();
      dec({5'h09, i[1], 3'h1, i[0], 6'h10}, ext, 0);
      chk("msize", op_size_q, i[0] ? POD_LONG : POD_WORD);
      chk("mmask", reg_mask_q, ext);
      chk("mdir", to_ea_q, !i[1]);
    end
    idle("alt_space_move");
    dec(16'ha000 | (rnd() & 16'h0fff), rnd(), 1);
    dec(16'h4afc, rnd(), 1);
    dec({4'h7, 3'(rnd()), 1'b1, 8'(rnd())}, rnd(), 1);
    dec(16'h06d0, rnd(), 1);
    dec(16'h0ed0, rnd(), 1);
    idle("illegal");
    end_of_test();
  end
endmodule : test_primary_opword_field_decoder
`default_nettype wire
